// ===== rtl/rmp_consts.svh
`ifndef RMP_CONSTS_SVH
`define RMP_CONSTS_SVH

// Clock rates in MHz
`define RMP_XTAL_MHZ       25
`define RMP_REFCLK_MHZ     50

// Register indices; byte address is index times four
`define RMP_IDX_CTRL       5'h00
`define RMP_IDX_STRAP      5'h19
`define RMP_IDX_INTCS      5'h1b
`define RMP_IDX_CTRL2      5'h1f

// Field positions
`define RMP_BIT_DUPLEX     8
`define RMP_BIT_ISOLATE    10
`define RMP_BIT_IRQPOL     9
`define RMP_BIT_EV_RXERR   0
`define RMP_BIT_EV_CRS     1
`define RMP_BIT_EV_TXEN    2

// Reset values
`define RMP_CTRL_RST       16'h0000
`define RMP_CTRL2_RST      16'h0000
`define RMP_INTEN_RST      8'h00

// Mode strap codes
`define RMP_MODE_RMII      3'h1
`define RMP_MODE_MII100    3'h4

// Management frame counts
`define RMP_MDIO_PRE       6'h20
`define RMP_MDIO_HDR_LAST  5'h0c
`define RMP_MDIO_DATA_LAST 5'h0f
`define RMP_MDIO_OP_RD     2'h2
`define RMP_MDIO_OP_WR     2'h1

`endif

// ===== rtl/rmp_pkg.sv
package rmp_pkg;

	typedef enum logic [4:0] {
		MS_IDLE = 5'h01,
		MS_HDR  = 5'h02,
		MS_TA   = 5'h04,
		MS_RD   = 5'h08,
		MS_WR   = 5'h10
	} rmp_mdio_state_type;

	typedef struct packed {
		logic        we;
		logic [4:0]  idx;
		logic [15:0] wdata;
	} rmp_mreq_type;

	typedef struct packed {
		logic [2:0] addr;
		logic [2:0] mode;
		logic       duplex_pin;
		logic       iso;
	} rmp_strap_type;

	typedef struct packed {
		logic       crs_dv;
		logic       rx_er;
		logic [1:0] rxd;
	} rmp_rx_type;

	typedef struct packed {
		logic       valid;
		logic [1:0] d;
	} rmp_dibit_type;

endpackage

// ===== rtl/rmp_mdio_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmp_consts.svh"

module rmp_mdio_slave (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  mdc_i,
	input  wire logic                  mdio_i,
	output logic                       mdio_o,
	output logic                       mdio_oe_o,
	input  wire logic [2:0]            phy_addr_i,
	input  wire logic [15:0]           rdata_i,
	output logic                       req_o,
	output rmp_pkg::rmp_mreq_type      req_data_o
);

	rmp_pkg::rmp_mdio_state_type state_q, state_d;
	logic [5:0]                  ones_q, ones_d;
	logic [4:0]                  cnt_q, cnt_d;
	logic [15:0]                 sh_q, sh_d;
	logic                        mdc_q;
	logic                        rd_q, rd_d;
	logic                        out_q, out_d;
	logic                        oe_q, oe_d;
	logic                        req_q, req_d;
	rmp_pkg::rmp_mreq_type       rq_q, rq_d;
	logic                        rise;
	logic [12:0]                 hdr;

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	assign rise = mdc_i & ~mdc_q;
	assign hdr  = {sh_q[11:0], mdio_i};

	always_comb begin
		state_d = state_q;
		ones_d  = ones_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		rd_d    = rd_q;
		out_d   = out_q;
		oe_d    = oe_q;
		req_d   = 1'b0;
		rq_d    = rq_q;
		// Read data captured one cycle after the request
		if (req_q && !rq_q.we) begin
			sh_d = rdata_i;
		end
		// [RULE13] Bits move at management clock rises
		if (rise) begin
			case (state_q)
				rmp_pkg::MS_IDLE: begin
					if (mdio_i) begin
						ones_d = (ones_q == `RMP_MDIO_PRE) ? ones_q : ones_q + 6'h01;
					end else if (ones_q == `RMP_MDIO_PRE) begin
						state_d = rmp_pkg::MS_HDR;
						cnt_d   = 5'h00;
						ones_d  = 6'h00;
					end else begin
						ones_d = 6'h00;
					end
				end
				rmp_pkg::MS_HDR: begin
					sh_d  = {sh_q[14:0], mdio_i};
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == `RMP_MDIO_HDR_LAST) begin
						rq_d.idx   = hdr[4:0];
						rq_d.we    = 1'b0;
						rq_d.wdata = 16'h0000;
						cnt_d      = 5'h00;
						state_d    = rmp_pkg::MS_IDLE;
						// Frames for another address are let pass silently
						if (hdr[12] && hdr[9:5] == {2'h0, phy_addr_i}) begin
							if (hdr[11:10] == `RMP_MDIO_OP_RD) begin
								state_d = rmp_pkg::MS_TA;
								rd_d    = 1'b1;
								req_d   = 1'b1;
							end else if (hdr[11:10] == `RMP_MDIO_OP_WR) begin
								state_d = rmp_pkg::MS_TA;
								rd_d    = 1'b0;
							end
						end
					end
				end
				rmp_pkg::MS_TA: begin
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == 5'h00) begin
						oe_d  = rd_q;
						out_d = 1'b0;
					end else begin
						cnt_d   = 5'h00;
						state_d = rd_q ? rmp_pkg::MS_RD : rmp_pkg::MS_WR;
						if (rd_q) begin
							out_d = sh_q[15];
							sh_d  = {sh_q[14:0], 1'b0};
						end
					end
				end
				rmp_pkg::MS_RD: begin
					cnt_d = cnt_q + 5'h01;
					out_d = sh_q[15];
					sh_d  = {sh_q[14:0], 1'b0};
					if (cnt_q == `RMP_MDIO_DATA_LAST) begin
						oe_d    = 1'b0;
						state_d = rmp_pkg::MS_IDLE;
					end
				end
				rmp_pkg::MS_WR: begin
					cnt_d = cnt_q + 5'h01;
					sh_d  = {sh_q[14:0], mdio_i};
					if (cnt_q == `RMP_MDIO_DATA_LAST) begin
						req_d      = 1'b1;
						rq_d.we    = 1'b1;
						rq_d.wdata = {sh_q[14:0], mdio_i};
						state_d    = rmp_pkg::MS_IDLE;
					end
				end
				default: begin
					state_d = rmp_pkg::MS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= rmp_pkg::MS_IDLE;
			ones_q  <= 6'h00;
			cnt_q   <= 5'h00;
			sh_q    <= 16'h0000;
			mdc_q   <= 1'b0;
			rd_q    <= 1'b0;
			out_q   <= 1'b0;
			oe_q    <= 1'b0;
			req_q   <= 1'b0;
			rq_q    <= '0;
		end else begin
			state_q <= state_d;
			ones_q  <= ones_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			mdc_q   <= mdc_i;
			rd_q    <= rd_d;
			out_q   <= out_d;
			oe_q    <= oe_d;
			req_q   <= req_d;
			rq_q    <= rq_d;
		end
	end

	assign mdio_o     = out_q;
	assign mdio_oe_o  = oe_q;
	assign req_o      = req_q;
	assign req_data_o = rq_q;

endmodule

`default_nettype wire

// ===== rtl/rmp_phy_mac_side.sv
// Summary of operation
// [RULE1] Reference clock for MAC from crystal clock
// [RULE2] Two receive bits per period while valid
// [RULE3] Capture two transmit bits while enabled
// [RULE4] One combined carrier sense/data valid output
// [RULE5] Receive error output flags bad data
// [RULE6] Address straps sampled at reset
// [RULE7] Duplex strap latched into control bit 8
// [RULE8] Three mode straps latched at reset
// [RULE9] Receive error pin latched as isolate
// [RULE10] Strap pins inputs in reset, outputs after (here the receive pins stay inputs while isolated)
// [RULE11] Interrupt pin from control/status register
// [RULE12] Control2 bit 9 sets interrupt polarity
// [RULE13] Management clock in, data synchronous
// [RULE14] Mode 001 reduced, 100 full; others reserved (here 100 leaves the datapath idle like the reserved codes)
// [RULE15] Duplex pin high half, low full
// [RULE16] Straps captured once, held until reset
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rmp_consts.svh"

module rmp_phy_mac_side #(
	parameter int unsigned REF_DIV = `RMP_XTAL_MHZ * 2 / `RMP_REFCLK_MHZ
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	// APB slave
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [11:0]           paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic [31:0]                prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	// Reference clock toward the MAC
	output logic                       ref_clk_en_o,
	output logic                       ref_tick_o,
	// Dual-role receive pins
	input  wire logic [1:0]            rxd_i,
	output logic [1:0]                 rxd_o,
	output logic [1:0]                 rxd_oe_o,
	input  wire logic                  crs_dv_i,
	output logic                       crs_dv_o,
	output logic                       crs_dv_oe_o,
	input  wire logic                  rx_er_i,
	output logic                       rx_er_o,
	output logic                       rx_er_oe_o,
	// Pure strap pins
	input  wire logic [1:0]            addr_strap_i,
	output logic [1:0]                 addr_strap_o,
	output logic [1:0]                 addr_strap_oe_o,
	input  wire logic [1:0]            mode_strap_i,
	output logic [1:0]                 mode_strap_o,
	output logic [1:0]                 mode_strap_oe_o,
	// Transmit from MAC
	input  wire logic                  tx_en_i,
	input  wire logic [1:0]            txd_i,
	// Line side
	input  wire logic                  line_rx_valid_i,
	input  wire logic [1:0]            line_rxd_i,
	input  wire logic                  line_rx_err_i,
	output rmp_pkg::rmp_dibit_type     line_tx_o,
	// Management port and interrupt
	input  wire logic                  mdc_i,
	input  wire logic                  mdio_i,
	output logic                       mdio_o,
	output logic                       mdio_oe_o,
	output logic                       irq_out_o,
	output logic [4:0]                 phy_bus_address_o
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic                  done_q, done_d;
	rmp_pkg::rmp_strap_type strap_q, strap_d;
	logic [15:0]           ctrl_q, ctrl_d;
	logic [15:0]           ctrl2_q, ctrl2_d;
	logic [7:0]            inten_q, inten_d;
	logic [7:0]            intsts_q, intsts_d;
	logic [31:0]           prdata_q, prdata_d;
	logic [7:0]            div_q, div_d;
	rmp_pkg::rmp_rx_type   rx_q, rx_d;
	rmp_pkg::rmp_dibit_type tx_q, tx_d;
	logic                  txen_q, txen_d;
	logic                  mreq;
	rmp_pkg::rmp_mreq_type mreq_data;
	logic [15:0]           mrdata;
	logic [4:0]            apb_idx;
	logic                  apb_ok;
	logic                  apb_acc;
	logic                  ref_en;
	logic                  active;
	logic [7:0]            ev;
	logic [7:0]            clr;

	function automatic logic idx_mapped(input logic [4:0] idx);
		idx_mapped = (idx == `RMP_IDX_CTRL) || (idx == `RMP_IDX_STRAP) ||
			(idx == `RMP_IDX_INTCS) || (idx == `RMP_IDX_CTRL2);
	endfunction

	function automatic logic [15:0] reg_read(input logic [4:0] idx);
		reg_read = 16'h0000;
		if (idx == `RMP_IDX_CTRL) begin
			reg_read = ctrl_q;
		end else if (idx == `RMP_IDX_STRAP) begin
			reg_read = {8'h00, strap_q};
		end else if (idx == `RMP_IDX_INTCS) begin
			// [RULE11] Enables high, pending low
			reg_read = {inten_q, intsts_q};
		end else if (idx == `RMP_IDX_CTRL2) begin
			reg_read = ctrl2_q;
		end
	endfunction

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign apb_idx   = paddr_i[6:2];
	assign apb_ok    = (paddr_i[1:0] == 2'h0) && (paddr_i[11:7] == 5'h00) && idx_mapped(apb_idx);
	assign apb_acc   = psel_i & penable_i;
	// Zero wait states: read data is registered in the setup cycle
	assign pready_o  = 1'b1;
	assign pslverr_o = apb_acc & ~apb_ok;
	assign prdata_o  = prdata_q;
	assign mrdata    = reg_read(mreq_data.idx);

	// ----------------------------------------
	// Reference clock and datapath
	// ----------------------------------------
	// [RULE1] Period tick derived from crystal clock
	assign ref_en       = (div_q == 8'h00);
	assign ref_tick_o   = ref_en & done_q;
	assign ref_clk_en_o = done_q;
	// [RULE14] Only the reduced code runs the datapath
	assign active = done_q && (strap_q.mode == `RMP_MODE_RMII) && !ctrl_q[`RMP_BIT_ISOLATE];

	always_comb begin
		div_d  = (div_q == 8'(REF_DIV - 1)) ? 8'h00 : div_q + 8'h01;
		rx_d   = rx_q;
		tx_d   = tx_q;
		txen_d = txen_q;
		ev     = 8'h00;
		if (ref_en) begin
			// [RULE2] Dibit presented with valid
			rx_d.crs_dv = active & line_rx_valid_i;
			rx_d.rxd    = (active & line_rx_valid_i) ? line_rxd_i : 2'h0;
			// [RULE5] Error only alongside valid data
			rx_d.rx_er  = active & line_rx_valid_i & line_rx_err_i;
			// [RULE3] Transmit dibit captured per period
			tx_d.valid  = active & tx_en_i;
			tx_d.d      = (active & tx_en_i) ? txd_i : 2'h0;
			txen_d      = active & tx_en_i;
			ev[`RMP_BIT_EV_RXERR] = rx_d.rx_er & ~rx_q.rx_er;
			ev[`RMP_BIT_EV_CRS]   = rx_d.crs_dv & ~rx_q.crs_dv;
			ev[`RMP_BIT_EV_TXEN]  = txen_d & ~txen_q;
		end
	end

	// ----------------------------------------
	// Straps and registers
	// ----------------------------------------
	always_comb begin
		done_d   = 1'b1;
		strap_d  = strap_q;
		ctrl_d   = ctrl_q;
		ctrl2_d  = ctrl2_q;
		inten_d  = inten_q;
		prdata_d = prdata_q;
		clr      = 8'h00;
		// [RULE16] Straps taken once after release
		if (!done_q) begin
			// [RULE6] Address from three straps
			strap_d.addr       = {rxd_i[1], addr_strap_i};
			// [RULE8] Mode from three straps
			strap_d.mode       = {crs_dv_i, mode_strap_i};
			strap_d.duplex_pin = rxd_i[0];
			// [RULE9] Isolate from error pin
			strap_d.iso        = rx_er_i;
			// [RULE7] Duplex bit set from strap
			// [RULE15] High pin means half duplex
			ctrl_d[`RMP_BIT_DUPLEX]  = ~rxd_i[0];
			ctrl_d[`RMP_BIT_ISOLATE] = rx_er_i;
		end
		if (psel_i && !penable_i && !pwrite_i) begin
			prdata_d = {16'h0000, reg_read(apb_idx)};
		end
		if (apb_acc && apb_ok) begin
			if (pwrite_i) begin
				if (apb_idx == `RMP_IDX_CTRL) begin
					ctrl_d = pwdata_i[15:0];
				end else if (apb_idx == `RMP_IDX_INTCS) begin
					inten_d = pwdata_i[15:8];
				end else if (apb_idx == `RMP_IDX_CTRL2) begin
					ctrl2_d = pwdata_i[15:0];
				end
			end else if (apb_idx == `RMP_IDX_INTCS) begin
				clr = clr | prdata_q[7:0];
			end
		end
		// Management writes land after the bus, so they win a collision
		if (mreq) begin
			if (mreq_data.we) begin
				if (mreq_data.idx == `RMP_IDX_CTRL) begin
					ctrl_d = mreq_data.wdata;
				end else if (mreq_data.idx == `RMP_IDX_INTCS) begin
					inten_d = mreq_data.wdata[15:8];
				end else if (mreq_data.idx == `RMP_IDX_CTRL2) begin
					ctrl2_d = mreq_data.wdata;
				end
			end else if (mreq_data.idx == `RMP_IDX_INTCS) begin
				clr = clr | intsts_q;
			end
		end
		// New events survive a read-clear in the same cycle
		intsts_d = (intsts_q & ~clr) | ev;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_q   <= 1'b0;
			strap_q  <= '0;
			ctrl_q   <= `RMP_CTRL_RST;
			ctrl2_q  <= `RMP_CTRL2_RST;
			inten_q  <= `RMP_INTEN_RST;
			intsts_q <= 8'h00;
			prdata_q <= 32'h0000_0000;
			div_q    <= 8'h00;
			rx_q     <= '0;
			tx_q     <= '0;
			txen_q   <= 1'b0;
		end else begin
			done_q   <= done_d;
			strap_q  <= strap_d;
			ctrl_q   <= ctrl_d;
			ctrl2_q  <= ctrl2_d;
			inten_q  <= inten_d;
			intsts_q <= intsts_d;
			prdata_q <= prdata_d;
			div_q    <= div_d;
			rx_q     <= rx_d;
			tx_q     <= tx_d;
			txen_q   <= txen_d;
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	// [RULE10] Pins float in reset; strap pins drive afterwards, receive pins only when not isolated
	assign rxd_oe_o        = {2{done_q & ~ctrl_q[`RMP_BIT_ISOLATE]}};
	// [RULE4] Single carrier/valid output
	assign crs_dv_oe_o     = done_q & ~ctrl_q[`RMP_BIT_ISOLATE];
	assign rx_er_oe_o      = done_q & ~ctrl_q[`RMP_BIT_ISOLATE];
	assign addr_strap_oe_o = {2{done_q}};
	assign mode_strap_oe_o = {2{done_q}};
	assign addr_strap_o    = 2'h0;
	assign mode_strap_o    = 2'h0;
	assign rxd_o           = rx_q.rxd;
	assign crs_dv_o        = rx_q.crs_dv;
	assign rx_er_o         = rx_q.rx_er;
	assign line_tx_o       = tx_q;
	assign phy_bus_address_o = {2'h0, strap_q.addr};
	// [RULE12] Low active unless polarity bit set
	assign irq_out_o = ~(ctrl2_q[`RMP_BIT_IRQPOL] ^ (|(intsts_q & inten_q)));

	// [RULE13] Management frames via serial engine
	rmp_mdio_slave u_mdio (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.mdc_i      (mdc_i),
		.mdio_i     (mdio_i),
		.mdio_o     (mdio_o),
		.mdio_oe_o  (mdio_oe_o),
		.phy_addr_i (strap_q.addr),
		.rdata_i    (mrdata),
		.req_o      (mreq),
		.req_data_o (mreq_data)
	);

endmodule

`default_nettype wire

// ===== tb/rmp_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Pin and strap checker
// ----------------------------
module rmp_props #(
	parameter int unsigned REF_DIV = 1
) (
	input wire logic			clk_i,
	input wire logic			rst_n_i,
	input wire logic			ref_clk_en_o,
	input wire logic			ref_tick_o,
	input wire logic [1:0]			rxd_i,
	input wire logic [1:0]			rxd_o,
	input wire logic [1:0]			rxd_oe_o,
	input wire logic			crs_dv_i,
	input wire logic			crs_dv_o,
	input wire logic			crs_dv_oe_o,
	input wire logic			rx_er_o,
	input wire logic [1:0]			addr_strap_i,
	input wire logic [1:0]			addr_strap_o,
	input wire logic [1:0]			addr_strap_oe_o,
	input wire logic [1:0]			mode_strap_i,
	input wire logic [1:0]			mode_strap_oe_o,
	input wire logic			tx_en_i,
	input wire logic [1:0]			txd_i,
	input wire logic			line_rx_valid_i,
	input wire logic [1:0]			line_rxd_i,
	input wire logic			line_rx_err_i,
	input wire rmp_pkg::rmp_dibit_type	line_tx_o,
	input wire logic			irq_out_o,
	input wire logic [4:0]			phy_bus_address_o
);
	logic		cap_q;
	logic		cap_d;
	logic [2:0]	mode_q;
	logic [2:0]	mode_d;
	logic [2:0]	addr_q;
	logic [2:0]	addr_d;
	logic		live;
	// Own copy of the straps, taken on the first edge out of reset
	always_comb begin
		cap_d = 1'b1;
		mode_d = cap_q ? mode_q : {crs_dv_i, mode_strap_i};
		addr_d = cap_q ? addr_q : {rxd_i[1], addr_strap_i};
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap_q <= 1'b0;
			mode_q <= 3'h0;
			addr_q <= 3'h0;
		end else begin
			cap_q <= cap_d;
			mode_q <= mode_d;
			addr_q <= addr_d;
		end
	end
	// Oe is low while isolated, so live also means not isolated
	assign live = cap_q && crs_dv_oe_o && mode_q == 3'h1;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_rx;
		live && $past(live) && $past(ref_tick_o) |-> crs_dv_o == $past(line_rx_valid_i)
			&& rxd_o == ($past(line_rx_valid_i) ? $past(line_rxd_i) : 2'h0);
	endproperty
	a_rx: assert property (p_rx) else $error("rx dibit mismatch");
	property p_rxer;
		live && $past(live) && $past(ref_tick_o) |-> rx_er_o == ($past(line_rx_valid_i) && $past(line_rx_err_i));
	endproperty
	a_rxer: assert property (p_rxer) else $error("rx error mismatch");
	property p_tx;
		live && $past(live) && $past(ref_tick_o) |-> line_tx_o.valid == $past(tx_en_i)
			&& (!line_tx_o.valid || line_tx_o.d == $past(txd_i));
	endproperty
	a_tx: assert property (p_tx) else $error("tx capture mismatch");
	property p_refuse;
		cap_q && mode_q != 3'h1 |-> !crs_dv_o && rxd_o == 2'h0 && !rx_er_o;
	endproperty
	a_refuse: assert property (p_refuse) else $error("non reduced mode drives data");
	property p_addr;
		cap_q |-> phy_bus_address_o == {2'h0, addr_q};
	endproperty
	a_addr: assert property (p_addr) else $error("bus address wrong");
	property p_oe;
		if (cap_q) (addr_strap_oe_o == 2'h3 && mode_strap_oe_o == 2'h3 && addr_strap_o == 2'h0)
		else (rxd_oe_o == 2'h0 && !crs_dv_oe_o);
	endproperty
	a_oe: assert property (p_oe) else $error("strap pin direction wrong");
	property p_ref;
		ref_clk_en_o == cap_q && (REF_DIV != 1 || ref_tick_o == cap_q);
	endproperty
	a_ref: assert property (p_ref) else $error("reference clock wrong");
	property p_irq;
		!cap_q |-> irq_out_o;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not idle high after reset");
	c_rx: cover property (live && crs_dv_o);
	c_tx: cover property (live && line_tx_o.valid);
	c_mode: cover property (cap_q && mode_q == 3'h4);
endmodule

bind rmp_phy_mac_side rmp_props #(.REF_DIV(REF_DIV)) u_props (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .ref_clk_en_o(ref_clk_en_o), .ref_tick_o(ref_tick_o),
	.rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .crs_dv_i(crs_dv_i), .crs_dv_o(crs_dv_o),
	.crs_dv_oe_o(crs_dv_oe_o), .rx_er_o(rx_er_o), .addr_strap_i(addr_strap_i), .addr_strap_o(addr_strap_o),
	.addr_strap_oe_o(addr_strap_oe_o), .mode_strap_i(mode_strap_i), .mode_strap_oe_o(mode_strap_oe_o),
	.tx_en_i(tx_en_i), .txd_i(txd_i), .line_rx_valid_i(line_rx_valid_i), .line_rxd_i(line_rxd_i),
	.line_rx_err_i(line_rx_err_i), .line_tx_o(line_tx_o), .irq_out_o(irq_out_o),
	.phy_bus_address_o(phy_bus_address_o));
`default_nettype wire

// ===== tb/rmp_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Transmitting station model
// ----------------------------
module rmp_mac_model (
	input  wire logic		clk_i,
	input  wire logic		rst_n_i,
	input  wire logic		tick_i,
	input  wire logic		send_i,
	input  wire logic [7:0]	byte_i,
	output logic			tx_en_o,
	output logic [1:0]		txd_o
);
	logic [7:0]	sh_q;
	logic [7:0]	sh_d;
	logic [2:0]	cnt_q;
	logic [2:0]	cnt_d;
	logic		en_d;
	logic [1:0]	txd_d;
	always_comb begin
		sh_d = sh_q;
		cnt_d = cnt_q;
		en_d = tx_en_o;
		// Idle data wanders so a sampler cannot rely on a stale value
		txd_d = tx_en_o ? txd_o : ~txd_o;
		if (send_i) begin
			sh_d = byte_i;
			cnt_d = 3'h4;
		end else if (tick_i && cnt_q != 3'h0) begin
			en_d = 1'b1;
			txd_d = sh_q[1:0];
			sh_d = sh_q >> 2;
			cnt_d = cnt_q - 3'h1;
		end else if (tick_i) begin
			en_d = 1'b0;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sh_q <= 8'h00;
			cnt_q <= 3'h0;
			tx_en_o <= 1'b0;
			txd_o <= 2'h0;
		end else begin
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			tx_en_o <= en_d;
			txd_o <= txd_d;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Bench
// ----------------------------
module tb_top;
	logic			clk_i = 1'b0;
	logic			rst_n_i = 1'b0;
	logic			psel = 1'b0;
	logic			pen = 1'b0;
	logic			pwr = 1'b0;
	logic [11:0]		paddr = 12'h000;
	logic [31:0]		pwd = 32'h0;
	logic			lv = 1'b0;
	logic			le = 1'b0;
	logic [1:0]		lrxd = 2'h0;
	logic			send = 1'b0;
	logic			mdc = 1'b0;
	logic			mdi = 1'b1;
	logic			mo, moe, mdp;
	logic [15:0]		mq;
	rmp_pkg::rmp_strap_type	st = 8'h00;
	rmp_pkg::rmp_dibit_type	ltx;
	logic [31:0]		prd, r;
	logic [1:0]		rxo, rxoe, rxp, aso, asoe, asp, mso, msoe, msp, txd;
	logic			prdy, perr, e, cro, croe, crp, ero, eroe, erp, tx_en, ref_en, tick, irq;
	logic [4:0]		pba;
	int			mismatches = 0;
	int			n_tests = 0;
	int			i;
	// Released pins fall back to their pull level
	assign rxp = {rxoe[1] ? rxo[1] : st.addr[2], rxoe[0] ? rxo[0] : st.duplex_pin};
	assign crp = croe ? cro : st.mode[2];
	assign erp = eroe ? ero : st.iso;
	assign asp = (asoe & aso) | (~asoe & st.addr[1:0]);
	assign msp = (msoe & mso) | (~msoe & st.mode[1:0]);
	// Released management line idles at its pull-up
	assign mdp = moe ? mo : mdi;
	always #20 clk_i = ~clk_i;
	rmp_phy_mac_side uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
		.ref_clk_en_o(ref_en), .ref_tick_o(tick), .rxd_i(rxp), .rxd_o(rxo), .rxd_oe_o(rxoe),
		.crs_dv_i(crp), .crs_dv_o(cro), .crs_dv_oe_o(croe), .rx_er_i(erp), .rx_er_o(ero), .rx_er_oe_o(eroe),
		.addr_strap_i(asp), .addr_strap_o(aso), .addr_strap_oe_o(asoe), .mode_strap_i(msp),
		.mode_strap_o(mso), .mode_strap_oe_o(msoe), .tx_en_i(tx_en), .txd_i(txd), .line_rx_valid_i(lv),
		.line_rxd_i(lrxd), .line_rx_err_i(le), .line_tx_o(ltx), .mdc_i(mdc), .mdio_i(mdp), .mdio_o(mo),
		.mdio_oe_o(moe), .irq_out_o(irq), .phy_bus_address_o(pba));
	rmp_mac_model u_mac (.clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i(tick), .send_i(send), .byte_i(8'hb4),
		.tx_en_o(tx_en), .txd_o(txd));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_i);
			if (prdy === 1'b1) break;
		end
		if (k == 20) begin
			mismatches++;
			results();
		end
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	// Station frame, two clocks per half bit; keeps the last 16 bits seen
	task automatic mdio_frame(input logic [63:0] f, output logic [15:0] q);
		int b;
		q = 16'h0000;
		for (b = 63; b >= 0; b--) begin
			mdc <= 1'b0;
			mdi <= f[b];
			repeat (2) @(posedge clk_i);
			q = {q[14:0], mdp};
			mdc <= 1'b1;
			repeat (2) @(posedge clk_i);
		end
		mdc <= 1'b0;
		mdi <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask
	// Strap levels share the strap register layout
	task automatic rst_to(input rmp_pkg::rmp_strap_type s);
		rst_n_i <= 1'b0;
		st <= s;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic results;
		$display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		rst_to(8'ha4);
		chk(pba, 5'h05);
		chk(ref_en, 1'b1);
		chk({msoe, asoe, mso, aso}, 8'hf0);
		rd(12'h064, 32'ha4);
		rd(12'h000, 32'h100);
		$display("straps done");
		apb(1'b1, 12'h06c, 32'h100);
		for (i = 0; i < 5; i++) begin
			lv <= (i < 4);
			lrxd <= i[1:0];
			le <= (i == 3);
			@(negedge clk_i);
			if (i > 0) chk({ero, cro, rxo}, {i == 4, 1'b1, 2'(i - 1)});
			@(posedge clk_i);
		end
		for (i = 0; i < 10; i++) begin
			@(negedge clk_i);
			if (irq === 1'b0) break;
		end
		chk(irq, 1'b0);
		@(posedge clk_i);
		rd(12'h06c, 32'h103);
		rd(12'h06c, 32'h100);
		apb(1'b1, 12'h07c, 32'h200);
		rd(12'h07c, 32'h200);
		apb(1'b1, 12'h06c, 32'h0);
		// Real error event while masked
		lv <= 1'b1;
		le <= 1'b1;
		@(posedge clk_i);
		lv <= 1'b0;
		le <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(irq, 1'b0);
		apb(1'b1, 12'h06c, 32'h100);
		chk(irq, 1'b1);
		apb(1'b0, 12'h010, 32'h0);
		chk(r, 32'h0);
		chk(e, 1'b1);
		$display("rx and irq done");
		send <= 1'b1;
		@(posedge clk_i);
		send <= 1'b0;
		for (i = 0; i < 10; i++) begin
			@(negedge clk_i);
			if (ltx.valid === 1'b1) break;
		end
		for (i = 0; i < 4; i++) begin
			chk(ltx, {1'b1, 2'(8'hb4 >> (2 * i))});
			@(negedge clk_i);
		end
		chk(ltx.valid, 1'b0);
		@(posedge clk_i);
		$display("tx done");
		rst_to(8'h53);
		chk(pba, 5'h02);
		chk(croe, 1'b0);
		rd(12'h064, 32'h53);
		rd(12'h000, 32'h400);
		apb(1'b1, 12'h000, 32'h0);
		lv <= 1'b1;
		lrxd <= 2'h3;
		st <= 8'hff;
		repeat (2) @(posedge clk_i);
		chk({cro, rxo}, 3'h0);
		rd(12'h064, 32'h53);
		chk(pba, 5'h02);
		$display("second reset done");
		mdio_frame({32'hffff_ffff, 2'h1, 2'h2, 5'h02, 5'h19, 2'h3, 16'hffff}, mq);
		chk(mq, 32'h0000_0053);
		mdio_frame({32'hffff_ffff, 2'h1, 2'h1, 5'h02, 5'h1f, 2'h2, 16'h0200}, mq);
		rd(12'h07c, 32'h200);
		$display("mdio done");
		results();
	end
endmodule
`default_nettype wire
